// file: hdl/acf_formatter.sv
`timescale 1ns/1ns
module acf_formatter #(
   parameter int WORD_W = acf_pkg::ACF_WORD_W,
   parameter int DEPTH = acf_pkg::ACF_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sample_strobe,
   input wire logic [acf_pkg::ACF_WORD_W-1:0] comparator_code,
   input wire logic upper_reference_sense,
   input wire logic top_bit_invert_select,
   input wire logic low_bits_invert_select,
   output logic [acf_pkg::ACF_WORD_W-1:0] conversion_word,
   output logic over_range,
   output logic word_valid,
   input wire logic word_ready,
   output logic strobe_ready
);
   import acf_pkg::*;

   // Comparator_code is the binary step number; upper_reference_sense high
   // means the input sits above the top sense voltage at this strobe.

   // Path: edge detect and latch, then FIFO, then output register.
   // With everything empty a word is offered three cycles after the edge.
   // The FIFO absorbs capture stalls at the cost of a fixed latency.
   typedef struct packed {
      logic strobe_d;
      logic [WORD_W-1:0] word;
      logic flag;
      logic valid;
      logic [WORD_W-1:0] out_word;
      logic out_flag;
      logic out_valid;
      logic ready;
   } acf_fmt_s;

   acf_fmt_s st;
   acf_fmt_s next_st;
   logic strobe_rise;
   logic [WORD_W-1:0] raw;
   logic [WORD_W-1:0] coded;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic [WORD_W:0] f_out_data;

   assign strobe_rise = sample_strobe && !st.strobe_d;
   // Over range forces the raw step to full scale before coding
   assign raw = upper_reference_sense ? WORD_W'(ACF_FULL_SCALE) : comparator_code;
   // Top bit and low bits invert independently
   assign coded = {raw[ACF_TOP_BIT] ^ ~top_bit_invert_select ^ 1'b1,
      raw[ACF_TOP_BIT-1:0] ^ {(WORD_W-1){low_bits_invert_select}}};

   always_comb begin
      next_st = st;
      next_st.strobe_d = sample_strobe;
      next_st.valid = 1'b0;
      // One cycle late, so a strobe right after the last slot fills is lost
      next_st.ready = f_in_ready;
      if (strobe_rise) begin
         next_st.word = coded;
         next_st.flag = upper_reference_sense;
         next_st.valid = 1'b1;
      end
      // Output stage: registered so ports come straight from flops
      if (!st.out_valid || word_ready) begin
         next_st.out_valid = f_out_valid;
         if (f_out_valid) begin
            next_st.out_word = f_out_data[WORD_W-1:0];
            next_st.out_flag = f_out_data[WORD_W];
         end
      end
   end

   assign f_out_ready = !st.out_valid || word_ready;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Back-pressure: a full FIFO drops a sample, reported via strobe_ready
   acf_fifo #(.WIDTH(WORD_W + 1), .DEPTH(DEPTH)) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(st.valid),
      .in_ready(f_in_ready),
      .in_data({st.flag, st.word}),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   assign conversion_word = st.out_word;
   assign over_range = st.out_flag;
   assign word_valid = st.out_valid;
   assign strobe_ready = st.ready;

   // Named steps of one conversion, shared by the checks below
   sequence s_rise;
      sample_strobe && !st.strobe_d;
   endsequence

   sequence s_rise_over;
      sample_strobe && !st.strobe_d && upper_reference_sense;
   endsequence

   sequence s_rise_in_range;
      sample_strobe && !st.strobe_d && !upper_reference_sense;
   endsequence

   sequence s_offer_stalled;
      word_valid && !word_ready;
   endsequence

   sequence s_out_load;
      !st.out_valid && f_out_valid;
   endsequence

   sequence s_out_take;
      f_out_valid && f_out_ready;
   endsequence

   // Latch stage: one sample per rising strobe edge, none otherwise
   a_latch_on_edge: assert property (@(posedge clock) disable iff (!arst_n)
      s_rise |=> st.valid && st.flag == $past(upper_reference_sense))
      else $error("strobe edge did not latch a sample");

   a_no_latch_else: assert property (@(posedge clock) disable iff (!arst_n)
      !strobe_rise |=> !st.valid)
      else $error("sample latched without strobe edge");

   a_edge_tracked: assert property (@(posedge clock) disable iff (!arst_n)
      1'b1 |=> st.strobe_d == $past(sample_strobe))
      else $error("strobe history lost");

   a_latch_single: assert property (@(posedge clock) disable iff (!arst_n)
      st.valid |=> !st.valid)
      else $error("held strobe latched twice");

   // Coding of the latched word
   a_coding_map: assert property (@(posedge clock) disable iff (!arst_n)
      s_rise_in_range |=> st.word ==
      ($past(comparator_code) ^ {$past(top_bit_invert_select),
      {(WORD_W-1){$past(low_bits_invert_select)}}}))
      else $error("wrong output coding");

   a_flag_set: assert property (@(posedge clock) disable iff (!arst_n)
      s_rise_over |=> st.flag)
      else $error("over range not flagged");

   a_flag_low: assert property (@(posedge clock) disable iff (!arst_n)
      s_rise_in_range |=> !st.flag)
      else $error("flag raised in range");

   a_flag_word: assert property (@(posedge clock) disable iff (!arst_n)
      s_rise_over |=> st.word ==
      {~$past(top_bit_invert_select) ^ 1'b0 ^ 1'b0,
      {(WORD_W-1){~$past(low_bits_invert_select)}}})
      else $error("over range word not full scale");

   // Output register: what the capture side sees
   a_flag_indep: assert property (@(posedge clock) disable iff (!arst_n)
      word_valid && over_range |-> conversion_word[WORD_W-2:0] ==
      {(WORD_W-1){conversion_word[0]}})
      else $error("flag disturbed data bits");

   a_out_full_scale: assert property (@(posedge clock) disable iff (!arst_n)
      word_valid && over_range |-> conversion_word ==
      {~top_bit_invert_select, {(WORD_W-1){~low_bits_invert_select}}})
      else $error("offered over range word not full scale");

   a_out_hold: assert property (@(posedge clock) disable iff (!arst_n)
      s_offer_stalled |=> word_valid && $stable(conversion_word)
      && $stable(over_range))
      else $error("output changed while stalled");

   a_out_loads: assert property (@(posedge clock) disable iff (!arst_n)
      s_out_load |=> word_valid)
      else $error("queued word not offered");

   a_out_copy: assert property (@(posedge clock) disable iff (!arst_n)
      s_out_take |=> conversion_word == $past(f_out_data[WORD_W-1:0])
      && over_range == $past(f_out_data[WORD_W]))
      else $error("queued word altered on the way out");

   a_out_idle: assert property (@(posedge clock) disable iff (!arst_n)
      (!st.out_valid || word_ready) && !f_out_valid |=> !word_valid)
      else $error("word offered with nothing queued");

   // Drop warning must follow the queue's fill level
   a_ready_mirror: assert property (@(posedge clock) disable iff (!arst_n)
      1'b1 |=> strobe_ready == $past(f_in_ready))
      else $error("strobe_ready does not follow queue");

   // Nothing is offered while reset is held
   a_reset_quiet: assert property (@(posedge clock)
      !arst_n |-> !word_valid && !over_range && !strobe_ready)
      else $error("outputs active in reset");
endmodule

// file: hdl/acf_pkg.sv
package acf_pkg;
   localparam int ACF_WORD_W = 10;
   localparam int ACF_FIFO_DEPTH = 8;
   // Raw comparator step code, 0..1023 in range
   localparam logic [9:0] ACF_FULL_SCALE = 10'h3ff;
   localparam logic [9:0] ACF_WORD_RST = 10'h000;
   localparam logic ACF_FLAG_RST = 1'b0;
   localparam int ACF_TOP_BIT = 9;
endpackage

// file: hdl/acf_fifo.sv
`timescale 1ns/1ns
module acf_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } acf_fifo_s;
   acf_fifo_s st;
   acf_fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (st.count != (AW+1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = mem[st.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[st.wr] <= in_data;
      end
   end

   a_fifo_no_overfill: assert property (@(posedge clock) disable iff (!arst_n)
      st.count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// file: bench/acf_capture.sv
`timescale 1ns/1ns
module acf_capture (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic word_valid,
   input wire logic stall,
   output logic word_ready,
   output logic taken
);
   // Stalls back the FIFO up
   assign word_ready = arst_n && !stall;
   assign taken = word_valid && word_ready;
endmodule

// file: bench/acf_formatter_tb.sv
`timescale 1ns/1ns
module acf_formatter_tb;
   import acf_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sample_strobe = 1'b0;
   logic [9:0] code = 10'h000;
   logic sense = 1'b0;
   logic top_sel = 1'b0;
   logic low_sel = 1'b0;
   logic stall = 1'b0;
   logic [9:0] word;
   logic over_range, word_valid, word_ready, strobe_ready, taken;
   logic [10:0] notes[$];
   int seed = 32'h917d;
   int fail_count = 0;
   int compares = 0;
   always #5 clock = ~clock;
   acf_formatter dut (.clock(clock), .arst_n(arst_n), .sample_strobe(sample_strobe),
      .comparator_code(code), .upper_reference_sense(sense),
      .top_bit_invert_select(top_sel), .low_bits_invert_select(low_sel),
      .conversion_word(word), .over_range(over_range), .word_valid(word_valid),
      .word_ready(word_ready), .strobe_ready(strobe_ready));
   acf_capture cap (.clock(clock), .arst_n(arst_n), .word_valid(word_valid),
      .stall(stall), .word_ready(word_ready), .taken(taken));
   task automatic wrap_up();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check_word(input logic [10:0] exp, input logic [10:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value flag_and_word exp %h got %h", exp, got);
      end
   endtask
   task automatic strobe(input logic [9:0] raw, input logic ovr);
      logic [9:0] w;
      w = (ovr ? ACF_FULL_SCALE : raw) ^ {top_sel, {9{low_sel}}};
      for (int i = 0; i < 50 && strobe_ready !== 1'b1; i++) @(posedge clock);
      notes.push_back({ovr, w});
      sample_strobe <= 1'b1;
      code <= raw;
      sense <= ovr;
      @(posedge clock);
      // Inputs scrambled after capture; only the edge may latch
      code <= ~raw;
      sense <= ~ovr;
      @(posedge clock);
      // Two cycles high, two low: even duty
      sample_strobe <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   always @(posedge clock) stall <= ($random(seed) & 3) == 0;
   always @(posedge clock) begin
      if (taken === 1'b1) begin
         if (notes.size() == 0) check_word(11'h7ff, {over_range, word});
         else check_word(notes.pop_front(), {over_range, word});
      end
   end
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end
   initial begin
      for (int c = 0; c < 4; c++) begin
         @(posedge clock);
         arst_n <= 1'b0;
         // Selects change only under reset, never while running
         {top_sel, low_sel} <= c[1:0];
         repeat (16) @(posedge clock);
         arst_n <= 1'b1;
         @(posedge clock);
         strobe(10'h000, 1'b0);
         strobe(10'h3ff, 1'b0);
         strobe(10'h200, 1'b0);
         strobe(10'h1ff, 1'b0);
         strobe($random(seed), 1'b1);
         for (int i = 0; i < 12; i++) strobe($random(seed), ($random(seed) & 7) == 0);
         for (int i = 0; i < 200 && notes.size() != 0; i++) @(posedge clock);
      end
      wrap_up();
   end
endmodule
